// file: core/dpc_top.sv
/*
  Pin control logic of an octal DAC: data coding, busy flag, clear,
  load latch, monitor routing and channel grouping.
  Assumes straps and control pins are asynchronous and are synchronised
  here; registers sit on a plain one-cycle port on REF_CLK.
*/
// Operation
// RL1: Channel data words are straight binary with the format strap low, two's complement high.
// RL2: Command words are always decoded as straight binary.
// RL3: The open-drain busy pin is pulled low while the correction engine runs.
// RL4: While clear is low every output is switched to its group analog ground.
// RL5: With clear high and load latch low all outputs reconnect to their amplifiers.
// RL6: The monitor is high impedance or routes a channel, reference or offset output.
// RL7: Channels 0 to 3 form group A and 4 to 7 group B, each with its own ground.
// RL8: While load latch is low each output latch is transparent to its data register.
`timescale 1ns/10ps
`include "dpc_consts.svh"
module dpc_top
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Pins
  input wire logic DATA_FORMAT_SELECT_IN,
  input wire logic OUTPUT_CLEAR_N_IN,
  input wire logic LOAD_LATCH_N_IN,
  output logic BUSY_N_OUT,
  output logic BUSY_N_OE_N_OUT,
  // Register port
  input wire logic [`DPC_ADDR_W-1:0] ADDR_IN,
  input wire logic [`DPC_DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [`DPC_DATA_W-1:0] RDATA_OUT,
  // Analog control
  output logic [`DPC_CH_N*`DPC_DATA_W-1:0] CH_CODE_OUT,
  output logic [`DPC_CH_N-1:0] CH_TO_AMP_OUT,
  output logic [`DPC_CH_N-1:0] CH_TO_GND_OUT,
  output logic [1:0] GROUP_GND_USE_OUT,
  output logic MON_HI_Z_OUT,
  output logic [3:0] MON_SRC_OUT
);
  typedef struct packed {
    logic [`DPC_CH_N-1:0][`DPC_DATA_W-1:0] data;
    logic [`DPC_CH_N-1:0][`DPC_DATA_W-1:0] latch;
    logic [`DPC_MON_W-1:0] mon;
    logic [`DPC_DATA_W-1:0] rdata;
    logic start;
    logic to_amp;
    logic [`DPC_CH_N-1:0] to_gnd;
  } dpc_top_st_t;

  dpc_top_st_t st;
  dpc_top_st_t next_st;
  logic [2:0] pins;
  logic fmt;
  logic clr_n;
  logic ld_n;
  logic busy;
  logic is_data;
  logic [`DPC_CH_W-1:0] sel;

  // Pin synchronisers
  dpc_sync #(.W(3)) u_sync (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .async_in({DATA_FORMAT_SELECT_IN, OUTPUT_CLEAR_N_IN, LOAD_LATCH_N_IN}),
    .sync_out(pins)
  );
  assign fmt = pins[2];
  assign clr_n = pins[1];
  assign ld_n = pins[0];

  // Correction engine
  dpc_corr u_corr (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .start_in(st.start),
    .busy_out(busy)
  );

  assign is_data = (ADDR_IN < `DPC_OFF_CMD);
  assign sel = ADDR_IN[`DPC_CH_W-1:0];

  // Register writes, latches, clear and read path
  always_comb
  begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.rdata = '0;
    if (WR_IN)
    begin
      if (is_data)
        // Two's complement becomes offset binary by flipping the MSB
        next_st.data[sel] = fmt ? {~WDATA_IN[`DPC_DATA_W-1], WDATA_IN[`DPC_DATA_W-2:0]}
                                : WDATA_IN; // RL1
      else if (ADDR_IN == `DPC_OFF_CMD)
        next_st.start = WDATA_IN[`DPC_CMD_START_BIT]; // RL2
      else if (ADDR_IN == `DPC_OFF_MON)
        next_st.mon = WDATA_IN[`DPC_MON_W-1:0]; // RL2
    end
    // Transparent output latches
    if (!ld_n)
      next_st.latch = next_st.data; // RL8
    // Ground switch level follows clear
    next_st.to_gnd = {`DPC_CH_N{~clr_n}}; // RL4
    if (!clr_n)
      next_st.to_amp = 1'b0;
    else if (!ld_n)
      next_st.to_amp = 1'b1; // RL5
    if (RD_IN)
    begin
      if (is_data)
        next_st.rdata = st.data[sel];
      else if (ADDR_IN == `DPC_OFF_MON)
        next_st.rdata = `DPC_DATA_W'(st.mon);
      else if (ADDR_IN == `DPC_OFF_STAT)
        next_st.rdata = `DPC_DATA_W'({busy, fmt, clr_n, ld_n});
      else if (ADDR_IN >= `DPC_OFF_LATCH0)
        next_st.rdata = st.latch[`DPC_CH_W'(ADDR_IN - `DPC_OFF_LATCH0)];
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st <= '0;
      st.mon <= `DPC_MON_RST;
    end
    else
      st <= next_st;
  end

  // Channel outputs and group grounds
  genvar g;
  generate
    for (g = 0; g < `DPC_CH_N; g++)
    begin : g_ch
      assign CH_CODE_OUT[g*`DPC_DATA_W +: `DPC_DATA_W] = st.latch[g];
      assign CH_TO_GND_OUT[g] = st.to_gnd[g]; // RL4
      assign CH_TO_AMP_OUT[g] = st.to_amp & ~st.to_gnd[g]; // RL5
    end
  endgenerate
  // Group A is channels 0..3, group B 4..7
  assign GROUP_GND_USE_OUT = {|st.to_gnd[`DPC_CH_N-1:`DPC_GRP_N],
                              |st.to_gnd[`DPC_GRP_N-1:0]}; // RL7

  // Monitor mux control
  assign MON_HI_Z_OUT = ~st.mon[`DPC_MON_EN_BIT]; // RL6
  assign MON_SRC_OUT = st.mon[3:0]; // RL6

  // Open drain busy: drive low while running
  assign BUSY_N_OUT = 1'b0;
  assign BUSY_N_OE_N_OUT = ~busy; // RL3

  assign RDATA_OUT = st.rdata;
endmodule : dpc_top

// file: core/dpc_consts.svh
/*
  Constants for the DAC pin control logic: widths, monitor select codes,
  register offsets, reset values and correction timing.
  Assumes inclusion by bare name from the package and modules.
*/
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// Data and channel geometry
`define DPC_DATA_W 12
`define DPC_CH_N 8
`define DPC_GRP_N 4
`define DPC_CH_W 3
`define DPC_ADDR_W 4

// Register offsets
`define DPC_OFF_DATA0 4'h0
`define DPC_OFF_CMD 4'h8
`define DPC_OFF_MON 4'h9
`define DPC_OFF_STAT 4'ha
`define DPC_OFF_LATCH0 4'hb

// Monitor select field (bit 4 enables, 3..0 source)
`define DPC_MON_W 5
`define DPC_MON_EN_BIT 4
`define DPC_MON_RST 5'h00
`define DPC_MON_SRC_REFA 4'h8
`define DPC_MON_SRC_REFB 4'h9
`define DPC_MON_SRC_OFSA 4'ha
`define DPC_MON_SRC_OFSB 4'hb

// Command word: bit 0 starts a correction run
`define DPC_CMD_START_BIT 0

// Correction run time, ns, and its cycle count at 40 MHz (25 ns)
`define DPC_CORR_TIME_NS 1000
`define DPC_CLK_NS 25
`define DPC_CORR_CYC ((`DPC_CORR_TIME_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_CNT_W 8

`endif

// file: core/dpc_pkg.sv
/*
  Types for the DAC pin control logic.
  Assumes the constants header is on the include path.
*/
package dpc_pkg;
  `include "dpc_consts.svh"

  typedef logic [`DPC_DATA_W-1:0] dpc_word_t;

  // Monitor route as seen by the analog mux
  typedef struct packed {
    logic hi_z;
    logic [3:0] src;
  } dpc_mon_t;

  typedef enum logic [0:0] {
    DPC_IDLE = 1'b0,
    DPC_RUN = 1'b1
  } dpc_corr_state_t;
endpackage : dpc_pkg

// file: core/dpc_sync.sv
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes the pins are asynchronous to REF_CLK.
*/
`timescale 1ns/10ps
module dpc_sync
  import dpc_pkg::*;
#(
  parameter int W = 3
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpc_sync_st_t;

  dpc_sync_st_t st;
  dpc_sync_st_t next_st;

  // Shift stages
  always_comb
  begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  // Register stages
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_out = st.s2;
endmodule : dpc_sync

// file: core/dpc_corr.sv
/*
  Correction engine timer: runs a fixed number of cycles per start.
  Assumes start is a single-cycle pulse from the same clock.
*/
`timescale 1ns/10ps
`include "dpc_consts.svh"
module dpc_corr
  import dpc_pkg::*;
#(
  parameter int RUN_CYC = `DPC_CORR_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  output logic busy_out
);
  typedef struct packed {
    dpc_corr_state_t state;
    logic [`DPC_CNT_W-1:0] cnt;
  } dpc_corr_st_t;

  dpc_corr_st_t st;
  dpc_corr_st_t next_st;

  // Run for RUN_CYC cycles after a start
  always_comb
  begin
    next_st = st;
    unique case (st.state)
      DPC_IDLE:
      begin
        if (start_in)
        begin
          next_st.state = DPC_RUN;
          next_st.cnt = `DPC_CNT_W'(RUN_CYC - 1);
        end
      end
      DPC_RUN:
      begin
        if (st.cnt == '0)
          next_st.state = DPC_IDLE;
        else
          next_st.cnt = st.cnt - `DPC_CNT_W'(1);
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '{state: DPC_IDLE, cnt: '0};
    else
      st <= next_st;
  end

  assign busy_out = (st.state == DPC_RUN);
endmodule : dpc_corr

// file: verif/dpc_board.sv
/*
  Board model on the far side: pull-up on the open-drain busy pin.
  Assumes the design drives the pin data low and enables it low.
*/
`timescale 1ns/10ps
module dpc_board
  import dpc_pkg::*;
(
  // Pin driver
  input wire logic drive_in,
  input wire logic oe_n_in,
  // Wire level
  output logic level_out
);
  // Pull-up wins when released
  assign level_out = oe_n_in ? 1'b1 : drive_in;
endmodule : dpc_board

// file: verif/dpc_top_sva.sv
/*
  Checker for the pin control logic, bound to the top module.
  Assumes pins are held steady long enough to pass the synchroniser.
*/
`timescale 1ns/10ps
`include "dpc_consts.svh"
module dpc_top_sva
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Pins
  input wire logic DATA_FORMAT_SELECT_IN,
  input wire logic OUTPUT_CLEAR_N_IN,
  input wire logic LOAD_LATCH_N_IN,
  input wire logic BUSY_N_OUT,
  input wire logic BUSY_N_OE_N_OUT,
  // Register port
  input wire logic [`DPC_ADDR_W-1:0] ADDR_IN,
  input wire logic [`DPC_DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  // Analog control
  input wire logic [`DPC_CH_N*`DPC_DATA_W-1:0] CH_CODE_OUT,
  input wire logic [`DPC_CH_N-1:0] CH_TO_AMP_OUT,
  input wire logic [`DPC_CH_N-1:0] CH_TO_GND_OUT,
  input wire logic [1:0] GROUP_GND_USE_OUT,
  input wire logic MON_HI_Z_OUT,
  input wire logic [3:0] MON_SRC_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // Start of a correction run, then a data write with latch open
  sequence s_start;
    WR_IN && ADDR_IN == 4'h8 && WDATA_IN[0];
  endsequence
  sequence s_wr0(f);
    (!LOAD_LATCH_N_IN && DATA_FORMAT_SELECT_IN == f)[*4] ##0 (WR_IN && ADDR_IN == 4'h0);
  endsequence
  a_busy_drive: assert property (BUSY_N_OUT == 1'b0) else $error("busy data high");
  a_busy_run: assert property (s_start |-> ##3 (!BUSY_N_OE_N_OUT)[*8] ##33 BUSY_N_OE_N_OUT)
    else $error("busy run length wrong");
  a_clr_ground: assert property ((!OUTPUT_CLEAR_N_IN)[*4] |-> CH_TO_GND_OUT == 8'hff
    && CH_TO_AMP_OUT == 8'h00) else $error("clear not grounding");
  a_amp_reconnect: assert property ((OUTPUT_CLEAR_N_IN && !LOAD_LATCH_N_IN)[*4]
    |-> CH_TO_AMP_OUT == 8'hff && CH_TO_GND_OUT == 8'h00) else $error("no reconnect");
  a_group_gnd: assert property (GROUP_GND_USE_OUT == {&CH_TO_GND_OUT[7:4],
    &CH_TO_GND_OUT[3:0]}) else $error("group ground wrong");
  a_mon_off: assert property (WR_IN && ADDR_IN == 4'h9 && !WDATA_IN[4] |=> MON_HI_Z_OUT)
    else $error("monitor not off");
  a_mon_route: assert property (WR_IN && ADDR_IN == 4'h9 && WDATA_IN[4] |=> !MON_HI_Z_OUT
    && MON_SRC_OUT == $past(WDATA_IN[3:0])) else $error("monitor route wrong");
  a_latch_bin: assert property (s_wr0(1'b0) |=> CH_CODE_OUT[11:0] == $past(WDATA_IN))
    else $error("binary latch wrong");
  a_latch_twos: assert property (s_wr0(1'b1) |=> CH_CODE_OUT[11:0] ==
    ($past(WDATA_IN) ^ 12'h800)) else $error("twos latch wrong");
endmodule : dpc_top_sva
bind dpc_top dpc_top_sva dpc_top_sva_inst (.*);

// file: verif/test_dpc_top.sv
/*
  Self-checking bench for the pin control logic.
  Assumes the board model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
module test_dpc_top
  import dpc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, fmt = 1'b0, clr_n = 1'b1, ld_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0, src;
  logic [11:0] wdata = 12'h000, rdata;
  logic [95:0] code;
  logic [7:0] amp, gnd;
  logic [1:0] grp;
  logic hiz, busy_d, busy_oe_n, busy;
  int mismatches = 0, num_checks = 0;
  dpc_top dpc_top_inst (.REF_CLK_IN(clk), .RST_IN(rst), .DATA_FORMAT_SELECT_IN(fmt),
    .OUTPUT_CLEAR_N_IN(clr_n), .LOAD_LATCH_N_IN(ld_n), .BUSY_N_OUT(busy_d),
    .BUSY_N_OE_N_OUT(busy_oe_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .CH_CODE_OUT(code), .CH_TO_AMP_OUT(amp), .CH_TO_GND_OUT(gnd),
    .GROUP_GND_USE_OUT(grp), .MON_HI_Z_OUT(hiz), .MON_SRC_OUT(src));
  dpc_board dpc_board_inst (.drive_in(busy_d), .oe_n_in(busy_oe_n), .level_out(busy));
  // Clock at 40 MHz
  always #12.5 clk = ~clk;
  task chk(input logic [95:0] s, input logic [95:0] e);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task close_out;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // One-cycle register accesses
  task wr_reg(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [11:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_reg
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  // Data coding through an open latch
  task t_format;
    wr_reg(4'h0, 12'h123);
    chk(code[11:0], 12'h123);
    rd_reg(4'h0, 12'h123);
    @(posedge clk);
    fmt <= 1'b1;
    wait_cyc(5);
    wr_reg(4'h0, 12'h123);
    chk(code[11:0], 12'h923);
    rd_reg(4'hb, 12'h923);
    rd_reg(4'ha, 12'h006);
  endtask : t_format
  // Command decoded as binary even in twos mode, busy low 40 cycles
  task t_busy;
    int n;
    wr_reg(4'h8, 12'h001);
    n = 0;
    while (busy === 1'b1 && n < 8)
    begin
      wait_cyc(1);
      n++;
    end
    n = 0;
    while (busy === 1'b0 && n < 60)
    begin
      wait_cyc(1);
      n++;
    end
    chk(n, 40);
    if (n == 0 || n >= 60)
      close_out();
  endtask : t_busy
  // Clear grounds both groups, release reconnects
  task t_clear;
    @(posedge clk);
    clr_n <= 1'b0;
    wait_cyc(5);
    chk({gnd, amp, grp}, {8'hff, 8'h00, 2'h3});
    @(posedge clk);
    clr_n <= 1'b1;
    wait_cyc(5);
    chk({gnd, amp, grp}, {8'h00, 8'hff, 2'h0});
  endtask : t_clear
  // Every monitor source, then off
  task t_monitor;
    for (int s = 0; s < 12; s++)
    begin
      wr_reg(4'h9, 12'h010 | 12'(s));
      chk({hiz, src}, {1'b0, 4'(s)});
    end
    wr_reg(4'h9, 12'h000);
    chk(hiz, 1'b1);
    rd_reg(4'h9, 12'h000);
  endtask : t_monitor
  initial
  begin
    wait_cyc(12);
    rst <= 1'b0;
    wait_cyc(4);
    chk({hiz, busy, rdata}, {1'b1, 1'b1, 12'h000});
    t_format();
    t_busy();
    t_clear();
    t_monitor();
    close_out();
  end
endmodule : test_dpc_top
